// [pkg/lpsm_pkg.sv]
// Package of types and constants for the LVDS pixel slot mapper
package lpsm_pkg;

  localparam int unsigned SLOTS         = 7;
  localparam int unsigned LANES         = 4;
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam logic [7:0]  WIDTH_18      = 8'h12;
  localparam logic [7:0]  WIDTH_24      = 8'h18;
  localparam logic [1:0]  ORDER_VESA    = 2'h1;
  localparam logic [1:0]  ORDER_JEIDA   = 2'h2;
  localparam logic [6:0]  IDLE_LANE     = 7'h00;
  localparam logic [1:0]  SYNC_RESET    = 2'h0;

  // One pixel with its timing signals
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic       de;
    logic       vsync;
    logic       hsync;
    logic       spare;
  } lpsm_pixel_t;

  // Seven-slot words of all lanes, slot 0 in bit 0
  typedef struct packed {
    logic [6:0] lane3;
    logic [6:0] lane2;
    logic [6:0] lane1;
    logic [6:0] lane0;
  } lpsm_word_t;

  localparam int unsigned WORD_W = $bits(lpsm_word_t);

endpackage

// [verilog/lpsm_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module lpsm_fifo
  import lpsm_pkg::*;
#(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,       // Clock
  input  wire logic             nrst,      // Async reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Room available
  output logic      [WIDTH-1:0] out_data,  // Read data, registered
  output logic                  out_valid, // Read data valid
  input  wire logic             out_ready  // Reader takes word
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Handshakes
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read data: head of queue, or the word being written into an empty queue
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_data <= '0;
    end else if (pop && cnt_q > (AW+1)'(1)) begin
      out_data <= mem_q[(rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1)];
    end else if (push && (cnt_q == '0 || (pop && cnt_q == (AW+1)'(1)))) begin
      out_data <= in_data;
    end
  end

endmodule

// [verilog/lpsm_mapper.sv]
// LVDS pixel slot mapper: pixel domain mapping and link domain output
// What this block does
// - Offer 24 bpp four lanes, 18 bpp three
// - VESA order slot layout per lane
// - JEIDA order slot layout per lane
// - VESA default, configuration selects JEIDA
// - 18 bpp sends JEIDA lanes 0-2 only
// - 18 bpp discards two colour LSBs
`timescale 1ns/1ps
module lpsm_mapper
  import lpsm_pkg::*;
(
  input  wire logic        core_clk,                     // Pixel clock, 125 MHz
  input  wire logic        nrst,                         // Async reset, active low
  input  wire logic        link_clk,                     // Serializer word clock
  input  lpsm_pixel_t      pixel_in,                     // Pixel and timing inputs
  input  wire logic        pixel_valid,                  // Pixel present this cycle
  output logic             pixel_ready,                  // Mapper can take pixel
  input  wire logic [7:0]  first_panel_width_select,     // 18 or 24
  input  wire logic [1:0]  first_panel_bit_order_select, // 1 VESA, 2 JEIDA
  output lpsm_word_t       lane_words,                   // Slot words, link domain
  output logic             lane_valid,                   // Words are fresh
  output logic             narrow_active                 // 18 bpp mode in force
);
  lpsm_pixel_t p;
  lpsm_word_t  vesa_w;
  lpsm_word_t  jeida_w;
  lpsm_word_t  map_d;
  lpsm_word_t  map_q;
  logic        map_vld_q;
  logic        narrow;
  logic        use_jeida;
  logic        f_ready;
  lpsm_word_t  f_data;
  logic        f_valid;
  logic        f_pop;
  logic        hold_full_q;
  logic        tog_q;
  logic [2:0]  ack_sync_q;
  logic        ack_seen_q;
  logic [2:0]  req_sync_q;
  logic        ack_tog_q;
  lpsm_word_t  xfer_q;

  assign p = pixel_in;

  // Mode decode; anything but 18 is treated as 24; 18 forces JEIDA, otherwise anything but 2 is VESA
  assign narrow    = (first_panel_width_select == WIDTH_18);
  assign use_jeida = narrow || (first_panel_bit_order_select == ORDER_JEIDA);

  // VESA slot layout, slot 0 in bit 0
  always_comb begin
    vesa_w.lane0 = {p.red[0], p.red[1], p.red[2], p.red[3], p.red[4], p.red[5],
                    p.green[0]};
    vesa_w.lane1 = {p.green[1], p.green[2], p.green[3], p.green[4], p.green[5],
                    p.blue[0], p.blue[1]};
    vesa_w.lane2 = {p.blue[2], p.blue[3], p.blue[4], p.blue[5], p.hsync, p.vsync,
                    p.de};
    vesa_w.lane3 = {p.red[6], p.red[7], p.green[6], p.green[7], p.blue[6],
                    p.blue[7], p.spare};
  end

  // JEIDA slot layout, slot 0 in bit 0
  always_comb begin
    jeida_w.lane0 = {p.red[2], p.red[3], p.red[4], p.red[5], p.red[6], p.red[7],
                     p.green[2]};
    jeida_w.lane1 = {p.green[3], p.green[4], p.green[5], p.green[6], p.green[7],
                     p.blue[2], p.blue[3]};
    jeida_w.lane2 = {p.blue[4], p.blue[5], p.blue[6], p.blue[7], p.hsync, p.vsync,
                     p.de};
    jeida_w.lane3 = {p.red[0], p.red[1], p.green[0], p.green[1], p.blue[0],
                     p.blue[1], p.spare};
  end

  // Word select; in 18 bpp the LSB lane is replaced by a constant
  always_comb begin
    map_d = use_jeida ? jeida_w : vesa_w;
    if (narrow) begin
      map_d.lane3 = IDLE_LANE;
    end
  end

  // Pixel ready follows the staging register's room
  assign pixel_ready = !map_vld_q || f_ready;

  // Capture colour, enable and sync inputs on one edge; 18 bpp leaves out the two colour LSBs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      map_q     <= '0;
      map_vld_q <= 1'b0;
    end else if (pixel_ready) begin
      map_q     <= map_d;
      map_vld_q <= pixel_valid;
    end
  end

  // Mode flag out, registered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      narrow_active <= 1'b0;
    end else begin
      narrow_active <= narrow;
    end
  end

  // Four word buffer in the data path
  lpsm_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .nrst      (nrst),
    .in_data   (map_q),
    .in_valid  (map_vld_q),
    .in_ready  (f_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // Handshake sender: hold one word stable until the link side acknowledges
  assign f_pop = f_valid && !hold_full_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_full_q <= 1'b0;
      tog_q       <= 1'b0;
      xfer_q      <= '0;
      ack_seen_q  <= 1'b0;
    end else begin
      if (f_pop) begin
        xfer_q      <= f_data;
        tog_q       <= ~tog_q;
        hold_full_q <= 1'b1;
      end else if (hold_full_q && (ack_sync_q[1] == ack_sync_q[2])
                   && (ack_sync_q[2] != ack_seen_q)) begin
        hold_full_q <= 1'b0;
      end
      if (ack_sync_q[1] == ack_sync_q[2]) begin
        ack_seen_q <= ack_sync_q[2];
      end
    end
  end

  // Acknowledge toggle brought back into the pixel domain
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_sync_q <= '0;
    end else begin
      ack_sync_q <= {ack_sync_q[1:0], ack_tog_q};
    end
  end

  // Request toggle brought into the link domain
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      req_sync_q <= '0;
    end else begin
      req_sync_q <= {req_sync_q[1:0], tog_q};
    end
  end

  // Link side takes the held word when a new request settles
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      ack_tog_q  <= 1'b0;
      lane_words <= '0;
      lane_valid <= 1'b0;
    end else begin
      lane_valid <= 1'b0;
      if ((req_sync_q[1] == req_sync_q[2]) && (req_sync_q[2] != ack_tog_q)) begin
        lane_words <= xfer_q;
        lane_valid <= 1'b1;
        ack_tog_q  <= req_sync_q[2];
      end
    end
  end

endmodule

// [tb/lpsm_mapper_monitor.sv]
// Port checker for the pixel slot mapper
`timescale 1ns/1ps
module lpsm_mapper_monitor
  import lpsm_pkg::*;
(
  input wire logic       core_clk,                 // Pixel clock
  input wire logic       nrst,                     // Reset, active low
  input wire logic       link_clk,                 // Link clock
  input wire logic       pixel_valid,              // Pixel offered
  input logic            pixel_ready,              // Pixel accepted
  input wire logic [7:0] first_panel_width_select, // Width code
  input lpsm_word_t      lane_words,               // Slot words
  input logic            lane_valid,               // Fresh word
  input logic            narrow_active             // Narrow mode
);
  // Pixel domain: mode flag and ready after reset
  AST_NARROW_ON: assert property (@(posedge core_clk) disable iff (!nrst)
    first_panel_width_select == WIDTH_18 |=> narrow_active) else $error("narrow not set");
  AST_NARROW_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
    first_panel_width_select != WIDTH_18 |=> !narrow_active) else $error("narrow not cleared");
  AST_READY_RST: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(nrst) |-> pixel_ready) else $error("not ready after reset");
  // Link domain: word strobe, word holding and idle lane 3; then the pixel-domain mode flag hold
  AST_VALID_PULSE: assert property (@(posedge link_clk) disable iff (!nrst)
    lane_valid |=> !lane_valid [*2]) else $error("strobe too long");
  AST_WORDS_HOLD: assert property (@(posedge link_clk) disable iff (!nrst)
    !lane_valid |-> $stable(lane_words)) else $error("words moved without strobe");
  AST_LANE3_IDLE: assert property (@(posedge link_clk) disable iff (!nrst)
    lane_valid && narrow_active |-> lane_words.lane3 == IDLE_LANE) else $error("lane3 busy");
  AST_VALID_RST: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(nrst) |-> !lane_valid) else $error("strobe after reset");
  AST_NARROW_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    $stable(first_panel_width_select) && $past(nrst) |=> $stable(narrow_active))
    else $error("mode flag moved");
  // Main scenarios
  COV_NARROW: cover property (@(posedge link_clk) lane_valid && narrow_active);
  COV_WIDE: cover property (@(posedge link_clk) lane_valid && !narrow_active);
  COV_REFUSE: cover property (@(posedge core_clk) pixel_valid && !pixel_ready);
endmodule

bind lpsm_mapper lpsm_mapper_monitor i_lpsm_mapper_monitor (.core_clk(core_clk), .nrst(nrst),
  .link_clk(link_clk), .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
  .first_panel_width_select(first_panel_width_select), .lane_words(lane_words),
  .lane_valid(lane_valid), .narrow_active(narrow_active));

// [tb/lpsm_panel_model.sv]
// Panel receiver model collecting slot words
`timescale 1ns/1ps
module lpsm_panel_model
  import lpsm_pkg::*;
(
  input wire logic link_clk,   // Link clock
  input lpsm_word_t lane_words, // Slot words
  input wire logic lane_valid  // Fresh word
);
  lpsm_word_t rx_words[$];
  // Take each fresh word in arrival order
  always @(posedge link_clk) begin
    if (lane_valid === 1'b1) begin
      rx_words.push_back(lane_words);
    end
  end
endmodule

// [tb/tb_lpsm_mapper.sv]
// Testbench for the pixel slot mapper
`timescale 1ns/1ps
module tb_lpsm_mapper;
  import lpsm_pkg::*;
  logic        core_clk;
  logic        link_clk;
  logic        nrst;
  logic        pixel_valid;
  logic        pixel_ready;
  logic        lane_valid;
  logic        narrow_active;
  logic [7:0]  wsel;
  logic [1:0]  osel;
  lpsm_pixel_t pixel_in;
  lpsm_word_t  lane_words;
  lpsm_word_t  exp_q[$];
  int          num_errors;
  int          n_checks;
  // Clocks with unrelated phase
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  lpsm_mapper i_lpsm_mapper (.core_clk(core_clk), .nrst(nrst), .link_clk(link_clk),
    .pixel_in(pixel_in), .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
    .first_panel_width_select(wsel), .first_panel_bit_order_select(osel),
    .lane_words(lane_words), .lane_valid(lane_valid), .narrow_active(narrow_active));
  lpsm_panel_model i_lpsm_panel_model (.link_clk(link_clk), .lane_words(lane_words),
    .lane_valid(lane_valid));
  // Expected words; the second order is the first on colours rotated right by two
  function automatic lpsm_word_t map_px(lpsm_pixel_t p, logic jeida, logic narrow);
    logic [7:0] r, g, b;
    lpsm_word_t w;
    r = jeida ? {p.red[1:0], p.red[7:2]} : p.red;
    g = jeida ? {p.green[1:0], p.green[7:2]} : p.green;
    b = jeida ? {p.blue[1:0], p.blue[7:2]} : p.blue;
    w.lane0 = {r[0], r[1], r[2], r[3], r[4], r[5], g[0]};
    w.lane1 = {g[1], g[2], g[3], g[4], g[5], b[0], b[1]};
    w.lane2 = {b[2], b[3], b[4], b[5], p.hsync, p.vsync, p.de};
    w.lane3 = narrow ? IDLE_LANE : {r[6], r[7], g[6], g[7], b[6], b[7], p.spare};
    return w;
  endfunction
  task automatic check_word(lpsm_word_t got, lpsm_word_t exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(logic got, logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Offer one pixel and hold it until taken
  task automatic send_px(lpsm_pixel_t p, logic jeida, logic narrow);
    int i;
    @(negedge core_clk);
    pixel_in = p;
    pixel_valid = 1'b1;
    exp_q.push_back(map_px(p, jeida, narrow));
    #1;
    for (i = 0; i < 200 && pixel_ready !== 1'b1; i++) @(negedge core_clk);
    if (i == 200) begin
      num_errors++;
      give_verdict();
    end
    @(posedge core_clk);
  endtask
  // Back-to-back pixels, then every word judged in order
  task automatic run_burst(int n, logic [27:0] base, logic jeida, logic narrow);
    int i;
    for (i = 0; i < n; i++) send_px(lpsm_pixel_t'(base ^ (28'(i) * 28'h6B3A5C7)), jeida, narrow);
    @(negedge core_clk);
    pixel_valid = 1'b0;
    for (i = 0; i < 3000 && i_lpsm_panel_model.rx_words.size() < n; i++) @(negedge core_clk);
    if (i == 3000) begin
      num_errors++;
      give_verdict();
    end
    while (exp_q.size() > 0) begin
      check_word(i_lpsm_panel_model.rx_words.pop_front(), exp_q.pop_front());
    end
  endtask
  task automatic test_vesa();
    check_bit(narrow_active, 1'b0);
    check_bit(pixel_ready, 1'b1);
    run_burst(7, 28'hFFFFFFF, 1'b0, 1'b0);
    $display("test vesa done");
  endtask
  task automatic test_jeida();
    osel = ORDER_JEIDA;
    run_burst(5, 28'h0000000, 1'b1, 1'b0);
    $display("test jeida done");
  endtask
  task automatic test_narrow();
    osel = ORDER_VESA;
    wsel = WIDTH_18;
    repeat (2) @(negedge core_clk);
    check_bit(narrow_active, 1'b1);
    run_burst(6, 28'h5A5A5A5, 1'b1, 1'b1);
    wsel = WIDTH_24;
    repeat (2) @(negedge core_clk);
    check_bit(narrow_active, 1'b0);
    run_burst(2, 28'hA5A5A5A, 1'b0, 1'b0);
    $display("test narrow done");
  endtask
  // Reset for 12 cycles, then the scenarios
  initial begin
    num_errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    pixel_valid = 1'b0;
    pixel_in = '0;
    wsel = WIDTH_24;
    osel = ORDER_VESA;
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    test_vesa();
    test_jeida();
    test_narrow();
    give_verdict();
  end
endmodule
